// >>> pinsel_pkg.sv
package pinsel_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam int          ADDR_W              = 4;
	localparam logic [3:0]  TIMER1_PFS_OFFSET   = 4'h0;
	localparam logic [31:0] TIMER1_PFS_RESET    = 32'h0000_0000;
	// Reserved bits 15:13 read as zero and ignore writes
	localparam logic [31:0] TIMER1_PFS_WMASK    = 32'hFFFF_1FFF;

	// ------------------------------------------------------------
	// Field positions (low bit of each field) and field widths
	// ------------------------------------------------------------
	localparam int CAPTURE3_SRC_LSB  = 29;
	localparam int CAPTURE2_SRC_LSB  = 26;
	localparam int CAPTURE1_SRC_LSB  = 23;
	localparam int CAPTURE0_SRC_LSB  = 20;
	localparam int FREERUN_SRC_LSB   = 18;
	localparam int DEADTIME_SRC_LSB  = 16;
	localparam int DEADTIME_SW_BIT   = 12;
	localparam int WAVE_OUT_LSB      = 0;
	localparam int CAPTURE_FIELD_W   = 3;
	localparam int TWO_BIT_FIELD_W   = 2;

	// ------------------------------------------------------------
	// Codes
	// ------------------------------------------------------------
	localparam logic [2:0] CAP_PIN0      = 3'h0;
	localparam logic [2:0] CAP_PIN0_ALT  = 3'h1;
	localparam logic [2:0] CAP_PIN1      = 3'h2;
	localparam logic [2:0] CAP_SYNC_LO   = 3'h4;
	localparam logic [2:0] CAP_SYNC_HI   = 3'h5;
	localparam logic [1:0] SEL2_PIN0     = 2'h0;
	localparam logic [1:0] SEL2_PIN0_ALT = 2'h1;
	localparam logic [1:0] SEL2_PIN1     = 2'h2;
	localparam logic [1:0] WAVE_OFF      = 2'h0;
	localparam logic [1:0] WAVE_PIN0     = 2'h1;
	localparam logic [1:0] WAVE_PIN1     = 2'h2;

	// Level fed to a capture or clock input under a prohibited code
	localparam logic       INACTIVE_LEVEL = 1'b0;

endpackage : pinsel_pkg

// >>> capture_route.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// One capture input selector
// ------------------------------------------------------------
module capture_route
	import pinsel_pkg::*;
(
	input  wire logic [2:0] source_field_i,
	input  wire logic       pin_alt0_i,
	input  wire logic       pin_alt1_i,
	input  wire logic       sync_lo_i,
	input  wire logic       sync_hi_i,
	output logic            capture_o
);

	always_comb
	begin
		case (source_field_i)
			CAP_PIN0, CAP_PIN0_ALT: capture_o = pin_alt0_i;
			CAP_PIN1:    capture_o = pin_alt1_i;
			CAP_SYNC_LO: capture_o = sync_lo_i;
			CAP_SYNC_HI: capture_o = sync_hi_i;
			// Prohibited codes park the channel at a quiet level
			default:     capture_o = INACTIVE_LEVEL;
		endcase
	end

endmodule : capture_route

// >>> timer1_pin_mux.sv
// The Wishbone register port and the address map are this design's own decisions.
`timescale 1ns/1ps
module timer1_pin_mux
	import pinsel_pkg::*;
#(
	parameter int CHANNELS = 4,
	parameter int WAVE_OUTS = 6
)
(
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	// Wishbone classic slave
	input  wire logic                   cyc_i,
	input  wire logic                   stb_i,
	input  wire logic                   we_i,
	input  wire logic [ADDR_W-1:0]      adr_i,
	input  wire logic [3:0]             sel_i,
	input  wire logic [31:0]            dat_i,
	output logic      [31:0]            dat_o,
	output logic                        ack_o,
	output logic                        err_o,
	// Capture routing
	input  wire logic [CHANNELS-1:0]    capture_pin0_i,
	input  wire logic [CHANNELS-1:0]    capture_pin1_i,
	input  wire logic [2*CHANNELS-1:0]  lin_sync_detect_i,
	output logic      [CHANNELS-1:0]    capture_ch_o,
	// Free-run clock and deadtime input routing
	input  wire logic                   freerun_pin0_i,
	input  wire logic                   freerun_pin1_i,
	output logic                        freerun_clock_o,
	input  wire logic                   deadtime_pin0_i,
	input  wire logic                   deadtime_pin1_i,
	output logic                        deadtime_input_o,
	// Waveform outputs
	input  wire logic                   deadtime_interrupt_flag_i,
	input  wire logic [WAVE_OUTS-1:0]   wave_i,
	output logic      [WAVE_OUTS-1:0]   wave_pin0_o,
	output logic      [WAVE_OUTS-1:0]   wave_pin1_o,
	output logic      [WAVE_OUTS-1:0]   wave_pin0_en_o,
	output logic      [WAVE_OUTS-1:0]   wave_pin1_en_o,
	output logic                        wave_gpio_takeover_o
);

	// ------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------
	// The register layout has room for exactly these counts
	if (CHANNELS != 4 || WAVE_OUTS != 6)
	begin : g_bad_param
		$error("timer1_pin_mux: layout fixes 4 channels, 6 outputs");
	end

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [31:0] pin_function;
		logic        ack;
		logic        err;
		logic [31:0] rdata;
	} state_t;

	state_t state;
	state_t next_state;

	function automatic logic [1:0] two_bit_field(input logic [31:0] r,
		input int lsb);
		two_bit_field = r[lsb +: TWO_BIT_FIELD_W];
	endfunction : two_bit_field

	function automatic logic route_two(input logic [1:0] code,
		input logic p0, input logic p1);
		case (code)
			SEL2_PIN0, SEL2_PIN0_ALT: route_two = p0;
			SEL2_PIN1: route_two = p1;
			default:   route_two = INACTIVE_LEVEL;
		endcase
	endfunction : route_two

	// ------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------
	logic        req;
	logic        hit;
	logic [31:0] lane_mask;
	logic [31:0] written;

	always_comb
	begin
		req       = cyc_i && stb_i && !state.ack && !state.err;
		hit       = adr_i == TIMER1_PFS_OFFSET;
		lane_mask = {{8{sel_i[3]}}, {8{sel_i[2]}},
			{8{sel_i[1]}}, {8{sel_i[0]}}} & TIMER1_PFS_WMASK;
		written   = (state.pin_function & ~lane_mask) | (dat_i & lane_mask);
		next_state       = state;
		next_state.ack   = 1'b0;
		next_state.err   = 1'b0;
		next_state.rdata = 32'h0000_0000;
		if (req)
		begin
			next_state.ack = hit;
			next_state.err = !hit;
			if (hit && we_i)
				next_state.pin_function = written;
			if (hit && !we_i)
				next_state.rdata = state.pin_function;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state.pin_function <= TIMER1_PFS_RESET;
			state.ack          <= 1'b0;
			state.err          <= 1'b0;
			state.rdata        <= 32'h0000_0000;
		end
		else
			state <= next_state;
	end

	assign ack_o = state.ack;
	assign err_o = state.err;
	assign dat_o = state.rdata;

	// ------------------------------------------------------------
	// Capture routing
	// ------------------------------------------------------------
	// Channel n takes serial sync n (code 100) or n+CHANNELS (101)
	localparam int CAP_LSB [4] = '{CAPTURE0_SRC_LSB, CAPTURE1_SRC_LSB,
		CAPTURE2_SRC_LSB, CAPTURE3_SRC_LSB};

	for (genvar n = 0; n < CHANNELS; n++)
	begin : g_capture
		capture_route u_route (
			.source_field_i (state.pin_function[CAP_LSB[n] +:
				CAPTURE_FIELD_W]),
			.pin_alt0_i     (capture_pin0_i[n]),
			.pin_alt1_i     (capture_pin1_i[n]),
			.sync_lo_i      (lin_sync_detect_i[n]),
			.sync_hi_i      (lin_sync_detect_i[n +
				CHANNELS]),
			.capture_o      (capture_ch_o[n])
		);
	end

	// ------------------------------------------------------------
	// Free-run clock, deadtime input
	// ------------------------------------------------------------
	assign freerun_clock_o = route_two(
		two_bit_field(state.pin_function, FREERUN_SRC_LSB),
		freerun_pin0_i, freerun_pin1_i);
	assign deadtime_input_o = route_two(
		two_bit_field(state.pin_function, DEADTIME_SRC_LSB),
		deadtime_pin0_i, deadtime_pin1_i);

	// ------------------------------------------------------------
	// Waveform outputs
	// ------------------------------------------------------------
	// The port block performs the GPIO handover; this only asks
	assign wave_gpio_takeover_o = state.pin_function[DEADTIME_SW_BIT]
		&& deadtime_interrupt_flag_i;

	for (genvar w = 0; w < WAVE_OUTS; w++)
	begin : g_wave
		logic [1:0] code;
		assign code = two_bit_field(state.pin_function,
			WAVE_OUT_LSB + TWO_BIT_FIELD_W * w);
		// Code 11 enables neither pin, same as disabled
		assign wave_pin0_en_o[w] = code == WAVE_PIN0;
		assign wave_pin1_en_o[w] = code == WAVE_PIN1;
		assign wave_pin0_o[w] = wave_pin0_en_o[w] && wave_i[w];
		assign wave_pin1_o[w] = wave_pin1_en_o[w] && wave_i[w];
	end

endmodule : timer1_pin_mux

// >>> capture_source_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Pin and sync-detect sources, new each cycle
// ----------------------------------------
module capture_source_model
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	output logic      [19:0] lines_o
);
	// An LFSR keeps every source toggling, so a stuck route shows
	always_ff @(posedge clk_i)
		if (rst_i)
			lines_o <= 20'h5A3C1;
		else
			lines_o <= {lines_o[18:0], lines_o[19] ^ lines_o[16]};
endmodule : capture_source_model

// >>> pin_mux_monitor.sv
`timescale 1ns/1ps
module pin_mux_monitor
(
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic [3:0]  adr_i,
	input wire logic [31:0] dat_o,
	input wire logic        ack_o,
	input wire logic        err_o,
	input wire logic [3:0]  capture_ch_o,
	input wire logic [3:0]  capture_pin0_i,
	input wire logic [5:0]  wave_pin0_en_o,
	input wire logic [5:0]  wave_pin1_en_o,
	input wire logic        wave_gpio_takeover_o,
	input wire logic        deadtime_interrupt_flag_i
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire tk = cyc_i && stb_i && !ack_o && !err_o;
	a_ack_mapped: assert property (tk && adr_i == 4'h0 |=> ack_o && !err_o)
		else $error("no ack for mapped access");
	a_err_unmapped: assert property (tk && adr_i != 4'h0 |=> err_o && !ack_o)
		else $error("no err for unmapped access");
	a_ack_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	a_no_stray: assert property (ack_o || err_o |-> $past(cyc_i && stb_i))
		else $error("answer without request");
	a_idle_data: assert property (!ack_o |-> dat_o == 32'h0)
		else $error("read data outside ack");
	a_reserved_zero: assert property (ack_o |-> dat_o[15:13] == 3'h0)
		else $error("reserved bits read nonzero");
	a_reset_route: assert property ($fell(rst_i) |->
		capture_ch_o == capture_pin0_i && wave_pin0_en_o == 6'h0)
		else $error("routing not at reset state");
	a_wave_one_pin: assert property (
		(wave_pin0_en_o & wave_pin1_en_o) == 6'h0)
		else $error("wave output on both pins");
	a_gpio_flag: assert property (wave_gpio_takeover_o |->
		deadtime_interrupt_flag_i) else $error("takeover without flag");
endmodule : pin_mux_monitor
bind timer1_pin_mux pin_mux_monitor u_pin_mux_monitor (.clk_i(clk_i),
	.rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .adr_i(adr_i),
	.dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
	.capture_ch_o(capture_ch_o), .capture_pin0_i(capture_pin0_i),
	.wave_pin0_en_o(wave_pin0_en_o), .wave_pin1_en_o(wave_pin1_en_o),
	.wave_gpio_takeover_o(wave_gpio_takeover_o),
	.deadtime_interrupt_flag_i(deadtime_interrupt_flag_i));

// >>> tb_timer1_pin_mux.sv
`timescale 1ns/1ps
module tb_timer1_pin_mux;
	import pinsel_pkg::*;
	logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, flag = 0;
	logic [3:0] adr_i = 4'h0, sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0;
	logic [5:0] wave_i = 6'h0;
	wire logic [31:0] dat_o;
	wire logic ack_o, err_o, fr_o, dt_o, tko;
	wire logic [3:0] cap;
	wire logic [5:0] e0, e1, p0, p1;
	wire logic [19:0] src;
	int n_errors = 0, checks = 0;
	always #50 clk_i = ~clk_i;
	capture_source_model u_capture_source_model (.clk_i(clk_i),
		.rst_i(rst_i), .lines_o(src));
	timer1_pin_mux u_timer1_pin_mux (.clk_i(clk_i), .rst_i(rst_i),
		.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
		.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.err_o(err_o), .capture_pin0_i(src[3:0]),
		.capture_pin1_i(src[7:4]), .lin_sync_detect_i(src[15:8]),
		.capture_ch_o(cap), .freerun_pin0_i(src[16]),
		.freerun_pin1_i(src[17]), .freerun_clock_o(fr_o),
		.deadtime_pin0_i(src[18]), .deadtime_pin1_i(src[19]),
		.deadtime_input_o(dt_o), .deadtime_interrupt_flag_i(flag),
		.wave_i(wave_i), .wave_pin0_o(p0), .wave_pin1_o(p1),
		.wave_pin0_en_o(e0), .wave_pin1_en_o(e1),
		.wave_gpio_takeover_o(tko));
	task conclude;
		if (n_errors == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : conclude
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// Classic cycle: hold everything until ack or err is sampled
	task wb(input logic w, input logic [3:0] a, input logic [3:0] s,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		int i;
		cyc_i <= 1;
		stb_i <= 1;
		we_i  <= w;
		adr_i <= a;
		sel_i <= s;
		dat_i <= d;
		for (i = 0; i < 20 && ack_o !== 1'b1 && err_o !== 1'b1; i++)
			@(posedge clk_i);
		if (i == 20)
		begin
			n_errors++;
			conclude();
		end
		else
		begin
			q = dat_o;
			e = err_o;
			cyc_i <= 0;
			stb_i <= 0;
			@(posedge clk_i);
		end
	endtask : wb
	function logic [3:0] exp_cap(logic [31:0] v, logic [15:0] s);
		for (int c = 0; c < 4; c++)
			case (v[20+3*c +: 3])
				3'h0, 3'h1: exp_cap[c] = s[c];
				3'h2: exp_cap[c] = s[4+c];
				3'h4: exp_cap[c] = s[8+c];
				3'h5: exp_cap[c] = s[12+c];
				default: exp_cap[c] = 1'b0;
			endcase
	endfunction : exp_cap
	function logic exp_two(logic [1:0] c, logic a, logic b);
		exp_two = (c < 2'h2) ? a : (c == 2'h2) ? b : 1'b0;
	endfunction : exp_two
	initial
	begin
		logic [31:0] q, v;
		logic [1:0]  w2, en;
		logic e;
		int k;
		k = $urandom(68285);
		repeat (10) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		wb(0, 4'h0, 4'hF, 32'h0, q, e);
		chk(q, 32'h0);
		for (k = 0; k < 48; k++)
		begin
			v = $urandom & 32'hFFFF_1FFF;
			// Random writes keep to the legal capture codes
			for (int c = 0; c < 4; c++)
				if (v[20+3*c +: 3] inside {3'h3, 3'h6, 3'h7})
					v[20+3*c +: 3] = 3'h2;
			// Corner cases reach the prohibited codes on purpose
			if (k < 8)
				v = {{4{k[2:0]}}, {2{k[1:0]}}, 3'h0, v[12], {6{k[1:0]}}};
			wave_i <= 6'($urandom);
			flag <= 1'($urandom);
			wb(1, 4'h0, 4'hF, v, q, e);
			wb(0, 4'h0, 4'hF, 32'h0, q, e);
			chk(q, v);
			@(negedge clk_i);
			chk(cap, exp_cap(v, src[15:0]));
			chk(fr_o, exp_two(v[19:18], src[16], src[17]));
			chk(dt_o, exp_two(v[17:16], src[18], src[19]));
			chk(tko, v[12] & flag);
			for (int j = 0; j < 6; j++)
			begin
				w2 = v[2*j +: 2];
				en = {w2 == 2'h2, w2 == 2'h1};
				chk({e1[j], e0[j]}, en);
				chk({p1[j], p0[j]}, en & {2{wave_i[j]}});
			end
			@(posedge clk_i);
		end
		wb(1, 4'h0, 4'hF, 32'h0, q, e);
		wb(1, 4'h0, 4'h2, 32'hFFFF_FFFF, q, e);
		wb(1, 4'h5, 4'hF, 32'hFFFF_FFFF, q, e);
		chk(e, 1'b1);
		wb(0, 4'h0, 4'hF, 32'h0, q, e);
		chk(q, 32'h0000_1F00);
		rst_i <= 1;
		repeat (2) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		wb(0, 4'h0, 4'hF, 32'h0, q, e);
		chk(q, 32'h0);
		conclude();
	end
endmodule : tb_timer1_pin_mux
